// ==== verilog/adcsq_consts.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_OFF_MODE      4'h0
`define ADCSQ_OFF_TIMING    4'h1
`define ADCSQ_OFF_TRIGGER   4'h2
`define ADCSQ_OFF_CHANNEL   4'h3
`define ADCSQ_OFF_CMPMODE   4'h4
`define ADCSQ_OFF_CMPTHR    4'h5
`define ADCSQ_OFF_CLKSRC    4'h6
`define ADCSQ_OFF_RESULT    4'h7
`define ADCSQ_BIT_BUSY      0
`define ADCSQ_BIT_TRIGMODE  6
`define ADCSQ_BIT_ENABLE    7
`define ADCSQ_BIT_HSPEED    0
`define ADCSQ_BIT_SLOWCLK   0
`define ADCSQ_RST_MODE      8'h00
`define ADCSQ_RST_TIMING    8'h00
`define ADCSQ_RST_TRIGGER   8'h00
`define ADCSQ_RST_CHANNEL   8'h00
`define ADCSQ_RST_CMPMODE   8'h00
`define ADCSQ_RST_CMPTHR    8'h00
`define ADCSQ_RST_CLKSRC    8'h00
`define ADCSQ_CLK_MHZ       10
`define ADCSQ_STAB_NS       1000
`define ADCSQ_STAB_CYC      ((`ADCSQ_STAB_NS * `ADCSQ_CLK_MHZ + 999) / 1000)
`define ADCSQ_CONV_BASE     8'h20
`endif

// ==== verilog/adcsq_pkg.sv ====
// types of the converter sequencer control block
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_STAB,
    ADCSQ_WAIT,
    ADCSQ_CONV
  } adcsq_state_e;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [7:0] dat;
  } adcsq_wbreq_s;
endpackage

// ==== verilog/adcsq_top.sv ====
// converter sequencer control with a classic wishbone register slave
// Operation
// - writes to the busy bit of the primary mode register are ignored
// - software trigger: a write to mode, trigger, channel, compare mode or compare threshold while busy restarts conversion from start
// - hardware trigger: a write to mode, trigger, channel, compare mode or compare threshold while busy aborts, waits for trigger
// - clearing converter enable stops operation; software clears it to save power
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_consts.svh"
module adcsq_top (
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  input  wire adcsq_pkg::adcsq_wbreq_s wb_req_i,
  output logic [7:0]                 wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  hw_trigger_i,
  input  wire logic [9:0]            analog_input_pins_i,
  output logic                       conversion_busy_o,
  output logic [3:0]                 active_channel_o
);
  adcsq_pkg::adcsq_state_e state;
  adcsq_pkg::adcsq_state_e next_state;
  logic [7:0] primary_mode_register;
  logic [7:0] timing_config_register;
  logic [7:0] trigger_source_register;
  logic [7:0] channel_select_register;
  logic [7:0] compare_mode_register;
  logic [7:0] compare_threshold_register;
  logic [7:0] clock_source_register;
  logic [7:0] result_register;
  logic [7:0] count;
  logic [7:0] next_count;

  // register index decode used by the write strobes
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction

  // where a conversion goes when it ends or is disturbed
  function automatic adcsq_pkg::adcsq_state_e after_run(input logic hw);
    if (hw) begin
      after_run = adcsq_pkg::ADCSQ_WAIT;
    end else begin
      after_run = adcsq_pkg::ADCSQ_CONV;
    end
  endfunction

  // ack answers a new request one cycle after it is seen
  wire       req_new   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  // writes land on the edge at which the master samples ack high
  wire       wr        = wb_ack_o & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we;
  wire [3:0] a         = wb_req_i.adr;
  wire       wr_mode   = wr & hit(a, `ADCSQ_OFF_MODE);
  wire       wr_timing = wr & hit(a, `ADCSQ_OFF_TIMING);
  wire       wr_trig   = wr & hit(a, `ADCSQ_OFF_TRIGGER);
  wire       wr_chan   = wr & hit(a, `ADCSQ_OFF_CHANNEL);
  wire       wr_cmpm   = wr & hit(a, `ADCSQ_OFF_CMPMODE);
  wire       wr_cmpt   = wr & hit(a, `ADCSQ_OFF_CMPTHR);
  wire       wr_clks   = wr & hit(a, `ADCSQ_OFF_CLKSRC);
  // slow clock source flag: mode register access is barred then
  wire       slow_clk  = clock_source_register[`ADCSQ_BIT_SLOWCLK];
  wire       wr_mode_ok = wr_mode & ~slow_clk;
  // a rewrite of these registers cuts a running conversion short
  wire       disturb   = wr_mode_ok | wr_trig | wr_chan | wr_cmpm | wr_cmpt;
  wire       enable    = primary_mode_register[`ADCSQ_BIT_ENABLE];
  wire       hw_mode   = primary_mode_register[`ADCSQ_BIT_TRIGMODE];
  wire       busy      = (state == adcsq_pkg::ADCSQ_CONV);
  wire [7:0] conv_len  = `ADCSQ_CONV_BASE + {5'h00, timing_config_register[3:1]};
  wire [3:0] chan      = channel_select_register[3:0];
  wire       chan_ok   = (chan < 4'ha);
  // last cycle of a stabilisation or conversion count
  wire       last_beat = (count == 8'h01);

  // conversion sequencer next state
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      adcsq_pkg::ADCSQ_IDLE: begin
        if (enable) begin
          next_state = adcsq_pkg::ADCSQ_STAB;
          next_count = 8'(`ADCSQ_STAB_CYC);
        end
      end
      adcsq_pkg::ADCSQ_STAB: begin
        next_count = count - 8'h01;
        if (last_beat) begin
          next_state = after_run(hw_mode);
          next_count = conv_len;
        end
      end
      adcsq_pkg::ADCSQ_WAIT: begin
        if (hw_trigger_i) begin
          next_state = adcsq_pkg::ADCSQ_CONV;
          next_count = conv_len;
        end
      end
      adcsq_pkg::ADCSQ_CONV: begin
        next_count = count - 8'h01;
        if (disturb || last_beat) begin
          next_state = after_run(hw_mode);
          next_count = conv_len;
        end
      end
    endcase
    if (!enable) begin
      next_state = adcsq_pkg::ADCSQ_IDLE;
      next_count = 8'h00;
    end
  end

  // sequencer state and count
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= adcsq_pkg::ADCSQ_IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // conversion result: sampled pin level, full scale or zero
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_register <= 8'h00;
    end else if (busy && !disturb && last_beat && enable) begin
      result_register <= (chan_ok && analog_input_pins_i[chan]) ? 8'hff : 8'h00;
    end
  end

  // mode register; barred while the cpu runs from a slow clock
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      primary_mode_register <= `ADCSQ_RST_MODE;
    end else if (wr_mode_ok) begin
      primary_mode_register <= {wb_req_i.dat[7:1], 1'b0};
    end
  end

  // timing; a change while enabled sets the length of the next conversion count, not the running one
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timing_config_register <= `ADCSQ_RST_TIMING;
    end else if (wr_timing) begin
      timing_config_register <= wb_req_i.dat;
    end
  end

  // trigger source
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trigger_source_register <= `ADCSQ_RST_TRIGGER;
    end else if (wr_trig) begin
      trigger_source_register <= wb_req_i.dat;
    end
  end

  // channel select; out of range channels convert as zero
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_select_register <= `ADCSQ_RST_CHANNEL;
    end else if (wr_chan) begin
      channel_select_register <= wb_req_i.dat;
    end
  end

  // compare mode
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_mode_register <= `ADCSQ_RST_CMPMODE;
    end else if (wr_cmpm) begin
      compare_mode_register <= wb_req_i.dat;
    end
  end

  // compare threshold
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_threshold_register <= `ADCSQ_RST_CMPTHR;
    end else if (wr_cmpt) begin
      compare_threshold_register <= wb_req_i.dat;
    end
  end

  // clock source; stands in for the cpu clock state
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clock_source_register <= `ADCSQ_RST_CLKSRC;
    end else if (wr_clks) begin
      clock_source_register <= wb_req_i.dat;
    end
  end

  // read mux; unmapped and barred reads give zero
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    unique case (a)
      // busy flag reads in bit 0
      `ADCSQ_OFF_MODE:    rd = slow_clk ? 8'h00 : {primary_mode_register[7:1], busy};
      `ADCSQ_OFF_TIMING:  rd = timing_config_register;
      `ADCSQ_OFF_TRIGGER: rd = trigger_source_register;
      `ADCSQ_OFF_CHANNEL: rd = channel_select_register;
      `ADCSQ_OFF_CMPMODE: rd = compare_mode_register;
      `ADCSQ_OFF_CMPTHR:  rd = compare_threshold_register;
      `ADCSQ_OFF_CLKSRC:  rd = clock_source_register;
      `ADCSQ_OFF_RESULT:  rd = result_register;
      default:            rd = 8'h00;
    endcase
  end

  // single cycle ack; dropped the cycle after
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 8'h00;
      conversion_busy_o <= 1'b0;
      active_channel_o  <= 4'h0;
    end else begin
      wb_ack_o          <= req_new;
      wb_dat_o          <= req_new ? rd : 8'h00;
      conversion_busy_o <= (next_state == adcsq_pkg::ADCSQ_CONV);
      active_channel_o  <= chan;
    end
  end
endmodule
`default_nettype wire

// ==== sim/adcsq_chk.sv ====
// port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk (
  input wire logic                    mclk_i,
  input wire logic                    resetn_i,
  input wire adcsq_pkg::adcsq_wbreq_s wb_req_i,
  input wire logic [7:0]              wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    conversion_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // writes land on the edge where ack is sampled high
  wire tk      = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_ack_o;
  logic en_q;
  logic hw_q;
  logic slow_q;
  wire wr_mode = tk && wb_req_i.adr == 4'h0 && !slow_q;
  wire wr_cfg  = tk && wb_req_i.adr inside {[4'h2:4'h5]};
  wire wr_clks = tk && wb_req_i.adr == 4'h6;
  // shadow of enable, trigger mode and slow clock bits
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q   <= 1'b0;
      hw_q   <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        en_q <= wb_req_i.dat[7];
        hw_q <= wb_req_i.dat[6];
      end
      if (wr_clks) begin
        slow_q <= wb_req_i.dat[0];
      end
    end
  end
  // config write landing on a running conversion
  sequence s_hit_busy;
    wr_cfg && en_q && conversion_busy_o;
  endsequence
  a_bit0_ro: assert property (wb_ack_o && !wb_req_i.we && wb_req_i.adr == 4'h0
    && !conversion_busy_o && !$past(conversion_busy_o) |-> !wb_dat_o[0])
    else $error("busy bit reads set while idle");
  a_sw_restart: assert property (s_hit_busy ##0 !hw_q |-> ##2 conversion_busy_o [*8])
    else $error("software trigger rewrite did not restart");
  a_hw_abort: assert property (s_hit_busy ##0 hw_q |-> ##[1:3] !conversion_busy_o)
    else $error("hardware trigger rewrite did not abort");
  a_idle_quiet: assert property ((!en_q) [*3] |-> !conversion_busy_o)
    else $error("busy while converter disabled");
  a_sw_start: assert property ($rose(en_q) && !hw_q |-> ##[8:16] conversion_busy_o)
    else $error("busy missing after enable");
  a_mode_barred: assert property (wb_ack_o && !wb_req_i.we && wb_req_i.adr == 4'h0
    && slow_q |-> wb_dat_o == 8'h00)
    else $error("mode register readable on slow clock");
endmodule
bind adcsq_top adcsq_chk i_chk (
  .mclk_i            (mclk_i),
  .resetn_i          (resetn_i),
  .wb_req_i          (wb_req_i),
  .wb_dat_o          (wb_dat_o),
  .wb_ack_o          (wb_ack_o),
  .conversion_busy_o (conversion_busy_o)
);
`default_nettype wire

// ==== sim/adcsq_pin_model.sv ====
// far side: analog pin levels and the hardware trigger line
`timescale 1ns/1ps
`default_nettype none
module adcsq_pin_model (
  input  wire logic       mclk_i,
  input  wire logic       fire_i,
  output var  logic [9:0] pins_o = 10'h155,
  output var  logic       trig_o = 1'b0
);
  // pins wander every cycle so no stale level can pass for a value
  always @(posedge mclk_i) begin
    pins_o <= {pins_o[8:0], ~pins_o[9]};
    trig_o <= fire_i;
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the converter sequencer control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                    mclk_i = 1'b0;
  logic                    resetn_i = 1'b0;
  logic                    fire = 1'b0;
  adcsq_pkg::adcsq_wbreq_s req = '0;
  logic [7:0]              dat, rd;
  logic                    ack, busy, trig;
  logic [9:0]              pins;
  logic [3:0]              chan;
  // rows: address, write data, expected read back
  logic [19:0]             rows [7] = '{20'h00100, 20'h10101, 20'h20101, 20'h30505,
                                        20'h4a5a5, 20'h55a5a, 20'h9ff00};
  int                      errors = 0;
  int                      checks_done = 0;
  always #50 mclk_i = ~mclk_i;
  adcsq_pin_model i_pins (.mclk_i(mclk_i), .fire_i(fire), .pins_o(pins), .trig_o(trig));
  adcsq_top i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .hw_trigger_i(trig), .analog_input_pins_i(pins),
    .conversion_busy_o(busy), .active_channel_o(chan));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{1'b1, 1'b1, w, a, d};
    do @(posedge mclk_i); while (ack !== 1'b1);
    rd = dat;
    req <= '0;
  endtask
  task automatic wait_busy(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) @(posedge mclk_i);
    chk({7'h00, busy}, {7'h00, v});
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the run needs
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b1, rows[i][19:16], rows[i][15:8]);
      wb(1'b0, rows[i][19:16], 8'h00);
      chk(rd, rows[i][7:0]);
    end
    chk({4'h0, chan}, 8'h05);
    wb(1'b1, 4'h6, 8'h01);
    wb(1'b1, 4'h0, 8'h80);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 8'h00);
    repeat (20) @(posedge mclk_i);
    chk({7'h00, busy}, 8'h00);
    wb(1'b1, 4'h6, 8'h00);
    // software trigger: start, then rewrite channel mid-conversion
    wb(1'b1, 4'h0, 8'h80);
    wait_busy(1'b1, 40);
    wb(1'b1, 4'h3, 8'h05);
    repeat (3) @(posedge mclk_i);
    chk({7'h00, busy}, 8'h01);
    wb(1'b0, 4'h0, 8'h00);
    chk({7'h00, rd[0]}, 8'h01);
    wb(1'b1, 4'h0, 8'h00);
    wait_busy(1'b0, 5);
    // hardware trigger mode; stays waiting with no trigger
    wb(1'b1, 4'h0, 8'hc0);
    repeat (20) @(posedge mclk_i);
    chk({7'h00, busy}, 8'h00);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    wait_busy(1'b1, 6);
    wb(1'b1, 4'h2, 8'h01);
    wait_busy(1'b0, 4);
    repeat (40) @(posedge mclk_i);
    chk({7'h00, busy}, 8'h00);
    wb(1'b1, 4'h0, 8'h00);
    // mid-run reset while a software conversion runs
    wb(1'b1, 4'h0, 8'h80);
    wait_busy(1'b1, 40);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({6'h00, ack, busy}, 8'h00);
    resetn_i <= 1'b1;
    wb(1'b0, 4'h3, 8'h00);
    chk(rd, 8'h00);
    chk({4'h0, chan}, 8'h00);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
